// ---- sdct_device.sv ----
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sdct_cfg.svh"
module sdct_device
  import sdct_pkg::*;
#(
  parameter int DM_W = 2,
  parameter int ROW_W = 12,
  parameter int COL_W = 9,
  parameter int MEM_AW = 10
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Synchronous reset, low active
  input wire logic cke, // Clock gate
  input wire logic cs_n, // Chip select, low active
  input wire logic ras_n, // Row strobe, low active
  input wire logic cas_n, // Column strobe, low active
  input wire logic we_n, // Write enable, low active
  input wire logic [1:0] ba, // Bank address
  input wire logic [ROW_W-1:0] addr, // Row or column address
  input wire logic [DM_W-1:0] dqm, // Byte mask
  input wire logic [8*DM_W-1:0] dq_in, // Data pin, input side
  output logic [8*DM_W-1:0] dq_out, // Data pin, output side
  output logic [DM_W-1:0] dq_oe_n, // Per-lane drive enable, low drives
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [31:0] reg_rdata // Read data, cycle after strobe
);
  localparam int DQ_W = 8 * DM_W;
  localparam int DEPTH = 2 ** MEM_AW;

  // ****************************************
  // Command decode and clock gating
  // ****************************************
  sdct_cmd_t cmd;
  sdct_cmd_t cmd_v;
  logic cke_q_reg;
  logic selfref_reg;
  logic [3:0] xsr_cnt_reg;
  logic active;

  sdct_cmd_dec u_dec (
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .cmd(cmd)
  );

  // Gate sampled now decides whether the next edge is live
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cke_q_reg <= 1'b1;
    end else begin
      cke_q_reg <= cke;
    end
  end

  // Commands count only on live edges outside self refresh
  assign active = cke_q_reg && !selfref_reg && (xsr_cnt_reg == 4'h0);
  assign cmd_v = active ? cmd : C_NOP;

  // ****************************************
  // Mode word and software config
  // ****************************************
  logic [2:0] bl_code_reg;
  logic [1:0] rl_reg;
  logic auto_grade_reg;
  logic [COL_W:0] bl_len;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bl_code_reg <= `SDCT_RST_BURST_CODE;
      rl_reg <= `SDCT_RST_READ_LAT;
    end else if (cmd_v == C_MODE) begin
      bl_code_reg <= addr[`SDCT_MODE_BL_LSB +: 3];
      rl_reg <= (addr[`SDCT_MODE_RL_LSB +: 3] == 3'h2) ? 2'h2 : 2'h3;
    end
  end

  // Grade bit steers self refresh entry
  always_ff @(posedge clk) begin
    if (!resetn) begin
      auto_grade_reg <= `SDCT_RST_AUTO_GRADE;
    end else if (reg_wr && reg_addr == `SDCT_REG_CFG) begin
      auto_grade_reg <= reg_wdata[`SDCT_CFG_AUTO_BIT];
    end
  end

  // Reserved burst codes take the full page length but end after one page
  always_comb begin
    case (bl_code_reg)
      3'h0: bl_len = (COL_W+1)'(1);
      3'h1: bl_len = (COL_W+1)'(2);
      3'h2: bl_len = (COL_W+1)'(4);
      3'h3: bl_len = (COL_W+1)'(8);
      default: bl_len = (COL_W+1)'(DEPTH > 0 ? (2 ** COL_W) : 1);
    endcase
  end

  // ****************************************
  // Banks, rows and auto precharge recovery
  // ****************************************
  logic [3:0] open_reg;
  logic [ROW_W-1:0] row_reg [4];
  logic [3:0] rec_cnt_reg;
  logic [1:0] rec_bank_reg;
  logic rd_burst_reg;
  logic wr_burst_reg;
  logic [COL_W:0] rem_reg;
  logic [COL_W-1:0] col_reg;
  logic [1:0] bank_reg;
  logic ap_reg;
  logic col_cmd;
  logic intr;
  logic rd_go;
  logic wr_go;
  logic ap_last;
  logic ap_wr;
  logic [1:0] cur_bank;
  logic [1:0] ap_bank;
  logic [COL_W-1:0] cur_col;
  logic [COL_W-1:0] col_mask;
  logic [COL_W-1:0] next_col;
  logic [MEM_AW-1:0] mem_idx;

  assign col_cmd = (cmd_v == C_READ) || (cmd_v == C_WRITE);
  // Any column command, stop, or precharge of the burst bank ends a burst
  assign intr = col_cmd || (cmd_v == C_STOP) ||
                ((cmd_v == C_PRE) && (ba == bank_reg || addr[`SDCT_AP_BIT]));
  assign rd_go = (cmd_v == C_READ) || (active && rd_burst_reg && !intr);
  assign wr_go = (cmd_v == C_WRITE) || (active && wr_burst_reg && !intr);
  assign cur_bank = col_cmd ? ba : bank_reg;
  assign cur_col = col_cmd ? addr[COL_W-1:0] : col_reg;
  // Wrap inside the burst boundary
  assign col_mask = COL_W'(bl_len - (COL_W+1)'(1));
  assign next_col = (cur_col & ~col_mask) | (COL_W'(cur_col + COL_W'(1)) & col_mask);
  // High address bits alias; the array is a scaled-down store
  assign mem_idx = MEM_AW'({cur_bank, row_reg[cur_bank], cur_col});
  assign ap_last = active && ((col_cmd && bl_len == (COL_W+1)'(1) && addr[`SDCT_AP_BIT]) ||
                   ((rd_burst_reg || wr_burst_reg) && !intr && rem_reg == (COL_W+1)'(1) &&
                    ap_reg && bl_code_reg != `SDCT_BL_FULL));
  assign ap_wr = wr_go;
  assign ap_bank = cur_bank;

  // Burst sequencing; frozen on suspended edges
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_burst_reg <= 1'b0;
      wr_burst_reg <= 1'b0;
      rem_reg <= '0;
      col_reg <= '0;
      bank_reg <= 2'h0;
      ap_reg <= 1'b0;
    end else if (active) begin
      if (col_cmd) begin
        rd_burst_reg <= (cmd_v == C_READ) && (bl_len != (COL_W+1)'(1));
        wr_burst_reg <= (cmd_v == C_WRITE) && (bl_len != (COL_W+1)'(1));
        rem_reg <= bl_len - (COL_W+1)'(1);
        col_reg <= next_col;
        bank_reg <= ba;
        ap_reg <= addr[`SDCT_AP_BIT];
      end else if (intr) begin
        rd_burst_reg <= 1'b0;
        wr_burst_reg <= 1'b0;
      end else if (rd_burst_reg || wr_burst_reg) begin
        col_reg <= next_col;
        if (bl_code_reg != `SDCT_BL_FULL) begin
          rem_reg <= rem_reg - (COL_W+1)'(1);
          if (rem_reg == (COL_W+1)'(1)) begin
            rd_burst_reg <= 1'b0;
            wr_burst_reg <= 1'b0;
          end
        end
      end
    end
  end

  // Self-timed precharge after the last word; write adds recovery
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rec_cnt_reg <= 4'h0;
      rec_bank_reg <= 2'h0;
    end else if (ap_last) begin
      rec_cnt_reg <= ap_wr ? 4'(`SDCT_WR_CYC + `SDCT_RP_CYC) : 4'(`SDCT_RP_CYC);
      rec_bank_reg <= ap_bank;
    end else if (rec_cnt_reg != 4'h0) begin
      rec_cnt_reg <= rec_cnt_reg - 4'h1;
    end
  end

  // Open rows per bank
  always_ff @(posedge clk) begin
    if (!resetn) begin
      open_reg <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        row_reg[b] <= '0;
      end
    end else begin
      if (rec_cnt_reg == 4'h1) begin
        open_reg[rec_bank_reg] <= 1'b0;
      end
      if (cmd_v == C_ACT) begin
        open_reg[ba] <= 1'b1;
        row_reg[ba] <= addr;
      end else if (cmd_v == C_PRE) begin
        if (addr[`SDCT_AP_BIT]) begin
          open_reg <= 4'h0;
        end else begin
          open_reg[ba] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Refresh and self refresh
  // ****************************************
  logic [15:0] refcnt_reg;
  logic ref_go;

  // Without self refresh the grade falls back to one auto refresh
  assign ref_go = (cmd_v == C_REF) && (cke || auto_grade_reg);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      refcnt_reg <= 16'h0;
    end else if (ref_go) begin
      refcnt_reg <= refcnt_reg + 16'h1;
    end
  end

  // Exit gap lets the row counter settle before commands
  always_ff @(posedge clk) begin
    if (!resetn) begin
      selfref_reg <= 1'b0;
      xsr_cnt_reg <= 4'h0;
    end else if (selfref_reg) begin
      if (cke) begin
        selfref_reg <= 1'b0;
        xsr_cnt_reg <= 4'(`SDCT_XSR_CYC);
      end
    end else begin
      if ((cmd_v == C_REF) && !cke && !auto_grade_reg) begin
        selfref_reg <= 1'b1;
      end
      if (xsr_cnt_reg != 4'h0) begin
        xsr_cnt_reg <= xsr_cnt_reg - 4'h1;
      end
    end
  end

  // ****************************************
  // Storage, read pipe and data pins
  // ****************************************
  logic [DQ_W-1:0] rd_word;
  logic [DM_W-1:0] lane_we;
  logic p1_v_reg;
  logic p2_v_reg;
  logic [DQ_W-1:0] p1_d_reg;
  logic [DQ_W-1:0] p2_d_reg;
  logic [DM_W-1:0] dqm_q_reg;
  logic src_v;
  logic [DQ_W-1:0] src_d;

  // One array per byte lane, so masked lanes keep their byte
  for (genvar i = 0; i < DM_W; i++) begin : g_lane
    logic [7:0] mem [DEPTH];
    assign lane_we[i] = wr_go && !dqm[i];
    assign rd_word[8*i +: 8] = mem[mem_idx];
    always_ff @(posedge clk) begin
      if (lane_we[i]) begin
        mem[mem_idx] <= dq_in[8*i +: 8];
      end
    end
  end

  // Read pipe stalls with the clock gate
  always_ff @(posedge clk) begin
    if (!resetn) begin
      p1_v_reg <= 1'b0;
      p2_v_reg <= 1'b0;
      p1_d_reg <= '0;
      p2_d_reg <= '0;
      dqm_q_reg <= '0;
    end else if (cke_q_reg) begin
      p1_v_reg <= rd_go;
      p1_d_reg <= rd_word;
      p2_v_reg <= p1_v_reg;
      p2_d_reg <= p1_d_reg;
      dqm_q_reg <= dqm;
    end
  end

  assign src_v = (rl_reg == 2'h2) ? p1_v_reg : p2_v_reg;
  assign src_d = (rl_reg == 2'h2) ? p1_d_reg : p2_d_reg;

  // Outputs hold during suspend; masked lanes float
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dq_out <= '0;
      dq_oe_n <= '1;
    end else if (cke_q_reg) begin
      dq_out <= src_d;
      for (int i = 0; i < DM_W; i++) begin
        dq_oe_n[i] <= !(src_v && !dqm_q_reg[i]);
      end
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  sdct_pwr_t pwr_reg;
  logic [1:0] pwr_bits;

  // Power state follows the gate one edge late
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pwr_reg <= PW_RUN;
    end else if (selfref_reg) begin
      pwr_reg <= PW_SELF;
    end else if (!cke_q_reg) begin
      pwr_reg <= (rd_burst_reg || wr_burst_reg) ? PW_SUSPEND : PW_PDOWN;
    end else begin
      pwr_reg <= PW_RUN;
    end
  end

  assign pwr_bits = pwr_reg;

  // Unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `SDCT_REG_CFG: reg_rdata <= {31'h0, auto_grade_reg};
        `SDCT_REG_STATUS: reg_rdata <= {19'h0, rd_burst_reg || wr_burst_reg, open_reg,
                                        rl_reg, 1'b0, bl_code_reg, pwr_bits};
        `SDCT_REG_REFCNT: reg_rdata <= {16'h0, refcnt_reg};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_suspend_freeze;
    !cke |=> ##1 ($stable(dq_out) && $stable(dq_oe_n));
  endproperty
  a_suspend_freeze: assert property (p_suspend_freeze) else $error("outputs moved in suspend");

  property p_resume_cmd;
    (!cke_q_reg && cke && !selfref_reg && xsr_cnt_reg == 4'h0) ##1 (cmd == C_REF && cke)
      |=> refcnt_reg == $past(refcnt_reg) + 16'h1;
  endproperty
  a_resume_cmd: assert property (p_resume_cmd) else $error("command lost after resume");

  property p_write_mask;
    (cmd_v == C_WRITE) |-> (lane_we == ~dqm);
  endproperty
  a_write_mask: assert property (p_write_mask) else $error("write mask not applied");

  property p_read_mask;
    (cke_q_reg && cke && dqm[0]) |-> ##2 dq_oe_n[0];
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("masked read lane driven");

  property p_pre_float_rl2;
    (cmd_v == C_PRE && rd_burst_reg && ba == bank_reg && rl_reg == 2'h2 && cke) ##1 (cke && cmd_v != C_READ)
      |=> &dq_oe_n;
  endproperty
  a_pre_float_rl2: assert property (p_pre_float_rl2) else $error("no float two after precharge");

  property p_pre_float_rl3;
    (cmd_v == C_PRE && rd_burst_reg && ba == bank_reg && rl_reg == 2'h3 && cke) ##1 (cke && cmd_v != C_READ)
      ##1 (cke && cmd_v != C_READ) |=> &dq_oe_n;
  endproperty
  a_pre_float_rl3: assert property (p_pre_float_rl3) else $error("no float three after precharge");

  property p_deselect;
    cs_n |=> refcnt_reg == $past(refcnt_reg);
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselected cycle acted");

  property p_no_selfref;
    (auto_grade_reg && cmd_v == C_REF && !cke) |=> !selfref_reg;
  endproperty
  a_no_selfref: assert property (p_no_selfref) else $error("self refresh on automotive grade");

  property p_one_refresh;
    ref_go |=> refcnt_reg == $past(refcnt_reg) + 16'h1;
  endproperty
  a_one_refresh: assert property (p_one_refresh) else $error("refresh count not one");

  property p_ap_close;
    (ap_last && ap_wr && open_reg[ap_bank] && !(cmd_v == C_ACT)) ##1 (cmd_v != C_ACT && !ap_last)[*2]
      |-> ##1 open_reg[rec_bank_reg] ##1 !open_reg[rec_bank_reg];
  endproperty
  a_ap_close: assert property (p_ap_close) else $error("auto precharge timing wrong");

  property p_activate;
    (cmd_v == C_ACT) |=> open_reg[$past(ba)];
  endproperty
  a_activate: assert property (p_activate) else $error("activate did not open row");

  c_read_burst: cover property (cmd_v == C_READ ##[1:4] !dq_oe_n[0]);
  c_self_refresh: cover property (!selfref_reg ##1 selfref_reg ##[1:20] !selfref_reg);
  c_suspend: cover property (pwr_reg == PW_SUSPEND);
  c_ap_write: cover property (ap_last && ap_wr);
endmodule
`default_nettype wire

// ---- sdct_cfg.svh ----
// Behaviour
// - Clock gate low suspends one cycle later.
// - Clock gate high resumes; command next cycle.
// - Write byte mask acts with zero latency.
// - Read byte mask floats data two cycles later.
// - Precharge floats read data after read latency.
// - Chip select high means no operation.
// - Automotive grade has no self refresh.
// - Each auto refresh does one refresh.
// - Auto-precharge period starts after write recovery.
`ifndef SDCT_CFG_SVH
`define SDCT_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define SDCT_REG_CFG 8'h00
`define SDCT_REG_STATUS 8'h04
`define SDCT_REG_REFCNT 8'h08
`define SDCT_CFG_AUTO_BIT 0
`define SDCT_RST_AUTO_GRADE 1'b0

// ****************************************
// Mode word layout and reset values
// ****************************************
`define SDCT_MODE_BL_LSB 0
`define SDCT_MODE_RL_LSB 4
`define SDCT_AP_BIT 10
`define SDCT_BL_FULL 3'h7
`define SDCT_RST_BURST_CODE 3'h3
`define SDCT_RST_READ_LAT 2'h3

// ****************************************
// Timing
// ****************************************
`define SDCT_CLK_PS 25000
`define SDCT_WR_EXTRA_PS 7500
`define SDCT_RP_PS 20000
`define SDCT_XSR_PS 75000
`define SDCT_XSR_MIN_CYC 2
`define SDCT_WR_CYC (1 + ((`SDCT_WR_EXTRA_PS + `SDCT_CLK_PS - 1) / `SDCT_CLK_PS))
`define SDCT_RP_CYC ((`SDCT_RP_PS + `SDCT_CLK_PS - 1) / `SDCT_CLK_PS)
`define SDCT_XSR_RAW ((`SDCT_XSR_PS + `SDCT_CLK_PS - 1) / `SDCT_CLK_PS)
`define SDCT_XSR_CYC ((`SDCT_XSR_RAW < `SDCT_XSR_MIN_CYC) ? `SDCT_XSR_MIN_CYC : `SDCT_XSR_RAW)
`define SDCT_SUSPEND_ENTRY_LAT 1
`define SDCT_READ_MASK_FLOAT_LAT 2

`endif

// ---- sdct_pkg.sv ----
`default_nettype none
package sdct_pkg;
  // Decoded command on the strobes
  typedef enum logic [2:0] {
    C_NOP, C_ACT, C_READ, C_WRITE, C_PRE, C_REF, C_MODE, C_STOP
  } sdct_cmd_t;
  // Power state shown in status
  typedef enum logic [1:0] {
    PW_RUN, PW_SUSPEND, PW_PDOWN, PW_SELF
  } sdct_pwr_t;
endpackage
`default_nettype wire

// ---- sdct_cmd_dec.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdct_cmd_dec
  import sdct_pkg::*;
(
  input wire logic cs_n, // Chip select, low active
  input wire logic ras_n, // Row strobe
  input wire logic cas_n, // Column strobe
  input wire logic we_n, // Write enable
  output sdct_cmd_t cmd // Decoded command
);
  // Deselect forces a no-operation whatever the strobes say
  always_comb begin
    if (cs_n) begin
      cmd = C_NOP;
    end else begin
      unique case ({ras_n, cas_n, we_n})
        3'b111: cmd = C_NOP;
        3'b011: cmd = C_ACT;
        3'b101: cmd = C_READ;
        3'b100: cmd = C_WRITE;
        3'b010: cmd = C_PRE;
        3'b001: cmd = C_REF;
        3'b000: cmd = C_MODE;
        3'b110: cmd = C_STOP;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- sdct_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Memory controller model
// ****************************************
module sdct_ctrl_model
  import sdct_pkg::*;
(
  input wire logic clk, // System clock
  output logic cke, // Clock gate
  output logic cs_n, // Chip select, low active
  output logic ras_n, // Row strobe
  output logic cas_n, // Column strobe
  output logic we_n, // Write enable
  output logic [1:0] ba, // Bank address
  output logic [11:0] addr, // Row or column address
  output logic [1:0] dqm, // Byte mask
  output logic [15:0] dq_in // Write data
);
  int edge_cnt = 0;
  int cmd_edge = 0;

  // Edge count, read by the bench between edges
  always @(posedge clk) begin
    edge_cnt++;
  end

  // Deselected and idle from time zero
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 2'h0;
    addr = 12'h000;
    dqm = 2'h0;
    dq_in = 16'h0000;
  end

  // One command per edge; mask and data ride with it
  task automatic issue(input sdct_cmd_t c, input logic [11:0] a, input logic [1:0] m,
    input logic [15:0] d, input logic wd, input logic k, input logic sel);
    logic [3:0] s;
    case (c)
      C_ACT: s = 4'h3;
      C_READ: s = 4'h5;
      C_WRITE: s = 4'h4;
      C_PRE: s = 4'h2;
      C_REF: s = 4'h1;
      C_MODE: s = 4'h0;
      C_STOP: s = 4'h6;
      default: s = 4'h7;
    endcase
    @(negedge clk);
    cmd_edge = edge_cnt + 2;
    @(posedge clk);
    cke <= k;
    {cs_n, ras_n, cas_n, we_n} <= {~sel, s[2:0]};
    ba <= 2'h0;
    addr <= a;
    dqm <= m;
    // Released data lines flip, so a stale word never passes
    dq_in <= wd ? d : ~dq_in;
  endtask
endmodule
`default_nettype wire

// ---- tb_sdram_command_timing.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_command_timing import sdct_pkg::*;;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n;
  logic [1:0] ba, dqm, dq_oe_n;
  logic [11:0] addr;
  logic [15:0] dq_in, dq_out;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  int failures = 0, total_checks = 0, last = 0, rl = 3;
  int seed = 32'h76d58c49;
  logic [15:0] mem [int], din_h [int], exp_d [int];
  logic [1:0] dqm_h [int], exp_oe [int];

  // 40 MHz clock, never varied while accesses run
  always #12.5 clk = ~clk;

  sdct_device sdct_device_i (.clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  sdct_ctrl_model sdct_ctrl_model_i (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, x, "register");
  endtask

  task automatic put(input sdct_cmd_t c, input logic [11:0] a, input logic [1:0] m = 2'h0,
    input logic [15:0] d = 16'h0, input logic wd = 1'b0, input logic k = 1'b1, input logic sel = 1'b1);
    sdct_ctrl_model_i.issue(c, a, m, d, wd, k, sel);
    last = sdct_ctrl_model_i.cmd_edge;
    dqm_h[last] = m;
    din_h[last] = d;
  endtask

  task automatic idle(input int n, input logic k = 1'b1);
    repeat (n) put(C_NOP, 12'h000, 2'h0, 16'h0, 1'b0, k);
  endtask

  // Write n random words; a short burst is cut by a stop
  task automatic wburst(input logic [11:0] col, input int n, input logic [1:0] m1);
    int w;
    put(C_WRITE, col, 2'h0, 16'($random(seed)), 1'b1);
    w = last;
    for (int k = 1; k < n; k++)
      put(C_NOP, 12'h000, (k == 1) ? m1 : 2'h0, 16'($random(seed)), 1'b1);
    if (n < 4)
      put(C_STOP, 12'h000);
    for (int k = 0; k < n; k++)
      for (int l = 0; l < 2; l++)
        if (!dqm_h[w + k][l])
          mem[int'(col) + k][8*l +: 8] = din_h[w + k][8*l +: 8];
  endtask

  // Burst of four with wrap; lane 0 masked on the second edge
  task automatic rburst(input logic [11:0] col, input logic pre);
    int r, c, j;
    put(C_READ, col);
    r = last;
    for (int k = 0; k < 5; k++) begin
      c = r + k + rl;
      j = int'(col & 12'hffc) + ((int'(col) + k) & 3);
      exp_d[c] = mem[j];
      exp_oe[c] = (k == 4 || (pre && c >= r + 2 + rl)) ? 2'h3 : ((c - 2 == r + 1) ? 2'h1 : 2'h0);
    end
    put(C_NOP, 12'h000, 2'h1);
    put(pre ? C_PRE : C_NOP, 12'h400);
    idle(2);
  endtask

  // Capture edge comparison, sampled between edges
  always @(negedge clk) begin
    int c;
    c = sdct_ctrl_model_i.edge_cnt + 1;
    if (exp_oe.exists(c)) begin
      chk(dq_oe_n, exp_oe[c], "drive enable");
      for (int l = 0; l < 2; l++)
        if (!exp_oe[c][l])
          chk(dq_out[8*l +: 8], exp_d[c][8*l +: 8], "read data");
      exp_oe.delete(c);
    end
  end

  // Watchdog well beyond the 140 or so cycles needed
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h04, 32'hcc);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    put(C_MODE, 12'h022);
    idle(2);
    put(C_REF, 12'h000);
    idle(2);
    put(C_REF, 12'h000);
    idle(2);
    put(C_REF, 12'h000, 2'h0, 16'h0, 1'b0, 1'b1, 1'b0);
    idle(2);
    rl = 2;
    rd(8'h08, 32'h2);
    rd(8'h04, 32'h88);
    put(C_ACT, 12'h005);
    idle(2);
    rd(8'h04, 32'h188);
    wburst(12'h004, 4, 2'h2);
    wburst(12'h004, 2, 2'h1);
    idle(1);
    rburst(12'h006, 1'b0);
    idle(3);
    rburst(12'h004, 1'b1);
    idle(4);
    rd(8'h04, 32'h88);
    // A refresh one edge after the gate drops is not taken
    idle(1, 1'b0);
    put(C_REF, 12'h000, 2'h0, 16'h0, 1'b0, 1'b0);
    idle(1, 1'b0);
    rd(8'h04, 32'h8a);
    idle(1);
    put(C_REF, 12'h000);
    idle(2);
    rd(8'h08, 32'h3);
    // Grade without self refresh counts and powers down
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h1);
    put(C_REF, 12'h000, 2'h0, 16'h0, 1'b0, 1'b0);
    idle(1, 1'b0);
    rd(8'h08, 32'h4);
    rd(8'h04, 32'h8a);
    idle(3);
    wr(8'h00, 32'h0);
    put(C_REF, 12'h000, 2'h0, 16'h0, 1'b0, 1'b0);
    idle(1, 1'b0);
    rd(8'h04, 32'h8b);
    idle(4);
    rd(8'h04, 32'h88);
    // Latency three: the mask still floats two edges after it, the precharge three edges after it
    put(C_MODE, 12'h032);
    idle(2);
    put(C_ACT, 12'h005);
    idle(2);
    rd(8'h04, 32'h1c8);
    rl = 3;
    rburst(12'h004, 1'b1);
    rd(8'h04, 32'hc8);
    // Fully masked write with auto precharge closes the bank by itself
    put(C_ACT, 12'h005);
    idle(2);
    rd(8'h04, 32'h1c8);
    put(C_WRITE, 12'h404, 2'h3);
    repeat (3) put(C_NOP, 12'h000, 2'h3);
    idle(5);
    rd(8'h04, 32'hc8);
    end_of_test();
  end
endmodule
`default_nettype wire
